// ===== verilog/emb_multiplier.sv
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps

module emb_multiplier
  import emb_pkg::*;
(
  // Clock and resets
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic aclr_i,
  input wire logic ce_i,
  // Register port
  input wire emb_pkg::emb_bus_t bus_i,
  output logic [emb_pkg::EMB_DATAW-1:0] rd_data_o,
  // Operands from fabric
  input wire emb_pkg::emb_opnd_t opnd_i,
  // Product to fabric
  output logic [emb_pkg::EMB_PRODW-1:0] product_o,
  output logic product_signed_o
);
  import emb_pkg::*;

  // ****************************************
  // Configuration register
  // ****************************************
  emb_cfg_t cfg_ff;
  logic [EMB_DATAW-1:0] rd_data_ff;
  logic [EMB_DATAW-1:0] nxt_rd_data;

  // ****************************************
  // Write decode
  // ****************************************
  logic cfg_wr;

  // Only the low byte is configuration; upper write bits are ignored
  always_comb
  begin
    cfg_wr = 1'b0;
    if (bus_i.wr && (bus_i.addr == EMB_CFG_OFS))
      cfg_wr = 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cfg_ff <= emb_cfg_t'(EMB_CFG_RST);
    else if (cfg_wr)
      cfg_ff <= emb_cfg_t'(bus_i.wdata[EMB_CFGW-1:0]);
  end

  // ****************************************
  // Sign select stage
  // ****************************************
  logic sign_a_ff;
  logic sign_b_ff;
  logic sign_a;
  logic sign_b;

  // Sign A register, cleared and enabled like every other stage
  always_ff @(posedge mclk_i or posedge aclr_i)
  begin
    if (aclr_i)
      sign_a_ff <= 1'b0;
    else if (ce_i)
      sign_a_ff <= opnd_i.sign_a;
  end

  // Sign B register
  always_ff @(posedge mclk_i or posedge aclr_i)
  begin
    if (aclr_i)
      sign_b_ff <= 1'b0;
    else if (ce_i)
      sign_b_ff <= opnd_i.sign_b;
  end

  // ****************************************
  // Sign interpretation
  // ****************************************
  // Plain levels, free to change between operations
  // Fabric ties both low when unused: unsigned product
  always_comb
  begin
    if (cfg_ff.sign_reg)
    begin
      sign_a = sign_a_ff;
      sign_b = sign_b_ff;
    end
    else
    begin
      sign_a = opnd_i.sign_a;
      sign_b = opnd_i.sign_b;
    end
  end

  // ****************************************
  // Input stage, one 9-bit section per lane
  // ****************************************
  logic [EMB_OPW-1:0] a_ff;
  logic [EMB_OPW-1:0] b_ff;
  logic [EMB_OPW-1:0] a_mul;
  logic [EMB_OPW-1:0] b_mul;
  logic [1:0] a_sel;
  logic [1:0] b_sel;
  logic [1:0] o_sel;

  // ****************************************
  // Stage selects
  // ****************************************
  // Whole-word mode uses the section 0 enables for both halves
  always_comb
  begin
    if (cfg_ff.dual)
    begin
      a_sel = cfg_ff.a_reg;
      b_sel = cfg_ff.b_reg;
      o_sel = cfg_ff.out_reg;
    end
    else
    begin
      a_sel = {2{cfg_ff.a_reg[0]}};
      b_sel = {2{cfg_ff.b_reg[0]}};
      o_sel = {2{cfg_ff.out_reg[0]}};
    end
  end

  // ****************************************
  // Operand registers
  // ****************************************
  // Operand A register; bypassed sections simply ignore it
  always_ff @(posedge mclk_i or posedge aclr_i)
  begin
    if (aclr_i)
      a_ff <= '0;
    else if (ce_i)
      a_ff <= opnd_i.a;
  end

  // Operand B register, kept apart so A and B stage independently
  always_ff @(posedge mclk_i or posedge aclr_i)
  begin
    if (aclr_i)
      b_ff <= '0;
    else if (ce_i)
      b_ff <= opnd_i.b;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sec
      localparam int unsigned LO = gi * EMB_HALFW;
      assign a_mul[LO +: EMB_HALFW] = a_sel[gi] ? a_ff[LO +: EMB_HALFW]
                                                : opnd_i.a[LO +: EMB_HALFW];
      assign b_mul[LO +: EMB_HALFW] = b_sel[gi] ? b_ff[LO +: EMB_HALFW]
                                                : opnd_i.b[LO +: EMB_HALFW];
    end
  endgenerate

  // ****************************************
  // Multiplier stage
  // ****************************************
  logic signed [EMB_OPW:0] a_ext;
  logic signed [EMB_OPW:0] b_ext;
  logic signed [2*EMB_OPW+1:0] full_prod;
  logic [EMB_PRODW-1:0] dual_prod;
  logic [EMB_PRODW-1:0] mul_out;
  logic prod_signed;

  // One extra bit carries the sign choice so one signed multiply serves
  // all four sign combinations; a zero top bit makes the operand unsigned
  always_comb
  begin
    a_ext = {sign_a & a_mul[EMB_OPW-1], a_mul};
    b_ext = {sign_b & b_mul[EMB_OPW-1], b_mul};
    full_prod = a_ext * b_ext;
  end

  // ****************************************
  // Lane products
  // ****************************************

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_half
      localparam int unsigned LO = gi * EMB_HALFW;
      logic signed [EMB_HALFW:0] ha;
      logic signed [EMB_HALFW:0] hb;
      logic signed [2*EMB_HALFW+1:0] hp;
      // Both halves share the single pair of selects
      always_comb
      begin
        ha = {sign_a & a_mul[LO+EMB_HALFW-1], a_mul[LO +: EMB_HALFW]};
        hb = {sign_b & b_mul[LO+EMB_HALFW-1], b_mul[LO +: EMB_HALFW]};
        hp = ha * hb;
      end
      // Low 18 bits hold every 9x9 result exactly
      assign dual_prod[gi*EMB_HPRODW +: EMB_HPRODW] = hp[EMB_HPRODW-1:0];
    end
  endgenerate

  // ****************************************
  // Result select
  // ****************************************
  // Both shapes are always computed; the mode only picks the result
  always_comb
  begin
    if (cfg_ff.dual)
      mul_out = dual_prod;
    else
      mul_out = full_prod[EMB_PRODW-1:0];
  end

  // Unsigned only when both operands are unsigned
  always_comb
  begin
    prod_signed = 1'b0;
    if (sign_a || sign_b)
      prod_signed = 1'b1;
  end

  // ****************************************
  // Output stage
  // ****************************************
  logic [EMB_PRODW-1:0] prod_ff;
  logic prod_signed_ff;
  logic [EMB_PRODW-1:0] nxt_product;

  // Product register, both 18-bit sections loaded together
  always_ff @(posedge mclk_i or posedge aclr_i)
  begin
    if (aclr_i)
      prod_ff <= '0;
    else if (ce_i)
      prod_ff <= mul_out;
  end

  // ****************************************
  // Sign flag stage
  // ****************************************
  // Signed flag follows the staging of section 0
  always_ff @(posedge mclk_i or posedge aclr_i)
  begin
    if (aclr_i)
      prod_signed_ff <= 1'b0;
    else if (ce_i)
      prod_signed_ff <= prod_signed;
  end

  // Bypassed sections stay combinational: zero added latency by design
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_out
      localparam int unsigned LO = gi * EMB_HPRODW;
      assign nxt_product[LO +: EMB_HPRODW] = o_sel[gi]
        ? prod_ff[LO +: EMB_HPRODW]
        : mul_out[LO +: EMB_HPRODW];
    end
  endgenerate

  // ****************************************
  // Output drive
  // ****************************************
  // Latency: one cycle per registered stage on a path, none when bypassed
  // Bypass must add no cycle, so these outputs are not all from flops
  assign product_o = nxt_product;
  always_comb
  begin
    if (o_sel[0])
      product_signed_o = prod_signed_ff;
    else
      product_signed_o = prod_signed;
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [EMB_DATAW-1:0] cfg_word;
  logic [EMB_DATAW-1:0] stat_word;

  // Register images, zero above their defined bits
  always_comb
  begin
    cfg_word = '0;
    cfg_word[EMB_CFGW-1:0] = cfg_ff;
    stat_word = '0;
    stat_word[EMB_STAT_SIGNED_BIT] = product_signed_o;
    stat_word[EMB_STAT_DUAL_BIT] = cfg_ff.dual;
  end

  // Unmapped reads and idle cycles return zero
  always_comb
  begin
    nxt_rd_data = '0;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        EMB_CFG_OFS:
          nxt_rd_data = cfg_word;
        EMB_STAT_OFS:
          nxt_rd_data = stat_word;
        default:
          nxt_rd_data = '0;
      endcase
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rd_data_ff <= '0;
    else
      rd_data_ff <= nxt_rd_data;
  end

  assign rd_data_o = rd_data_ff;

endmodule : emb_multiplier

// ===== verilog/emb_pkg.sv
package emb_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned EMB_OPW = 18;
  localparam int unsigned EMB_HALFW = 9;
  localparam int unsigned EMB_PRODW = 36;
  localparam int unsigned EMB_HPRODW = 18;
  localparam int unsigned EMB_ADDRW = 8;
  localparam int unsigned EMB_DATAW = 32;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] EMB_CFG_OFS = 8'h00;
  localparam logic [7:0] EMB_STAT_OFS = 8'h04;
  localparam int unsigned EMB_CFGW = 8;
  localparam logic [7:0] EMB_CFG_RST = 8'h00;
  localparam int unsigned EMB_STAT_SIGNED_BIT = 0;
  localparam int unsigned EMB_STAT_DUAL_BIT = 1;

  // ****************************************
  // Types
  // ****************************************
  // Bit 0 mode, [2:1] A sections, [4:3] B sections, 5 sign, [7:6] out
  typedef struct packed {
    logic [1:0] out_reg;
    logic sign_reg;
    logic [1:0] b_reg;
    logic [1:0] a_reg;
    logic dual;
  } emb_cfg_t;

  typedef struct packed {
    logic [EMB_OPW-1:0] a;
    logic [EMB_OPW-1:0] b;
    logic sign_a;
    logic sign_b;
  } emb_opnd_t;

  typedef struct packed {
    logic [EMB_ADDRW-1:0] addr;
    logic [EMB_DATAW-1:0] wdata;
    logic wr;
    logic rd;
  } emb_bus_t;

endpackage : emb_pkg

// ===== verif/emb_multiplier_chk.sv
`timescale 1ns/1ps
module emb_multiplier_chk
  import emb_pkg::*;
(
  // Clock and controls
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic aclr_i,
  input wire logic ce_i,
  // Bus and data
  input wire emb_pkg::emb_bus_t bus_i,
  input wire logic [emb_pkg::EMB_DATAW-1:0] rd_data_o,
  input wire emb_pkg::emb_opnd_t opnd_i,
  input wire logic [emb_pkg::EMB_PRODW-1:0] product_o,
  input wire logic product_signed_o
);
  logic [7:0] cfg_ff;
  logic [35:0] e36;
  logic [17:0] e0;
  logic [17:0] e1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Shadow config, so checks know the staging
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cfg_ff <= 8'h00;
    else if (bus_i.wr && bus_i.addr == 8'h00)
      cfg_ff <= bus_i.wdata[7:0];
  end
  assign e36 = $signed({opnd_i.sign_a & opnd_i.a[17], opnd_i.a})
    * $signed({opnd_i.sign_b & opnd_i.b[17], opnd_i.b});
  assign e0 = $signed({opnd_i.sign_a & opnd_i.a[8], opnd_i.a[8:0]})
    * $signed({opnd_i.sign_b & opnd_i.b[8], opnd_i.b[8:0]});
  assign e1 = $signed({opnd_i.sign_a & opnd_i.a[17], opnd_i.a[17:9]})
    * $signed({opnd_i.sign_b & opnd_i.b[17], opnd_i.b[17:9]});
  chk_bypass_prod:
  assert property (cfg_ff == 8'h00 |-> product_o == e36 &&
    product_signed_o == (opnd_i.sign_a | opnd_i.sign_b)) else $error("bad");
  chk_dual_lanes:
  assert property (cfg_ff == 8'h01 |-> product_o == {e1, e0}) else $error("bad");
  chk_out_stage:
  assert property (cfg_ff == 8'h40 && ce_i && !aclr_i && !bus_i.wr |=>
    aclr_i || product_o == $past(e36)) else $error("bad");
  chk_ce_hold:
  assert property (cfg_ff[6] && !cfg_ff[0] && !ce_i && !bus_i.wr |=>
    aclr_i || $stable(product_o)) else $error("bad");
  chk_aclr_clear:
  assert property (aclr_i && cfg_ff[6] && !cfg_ff[0] |-> product_o == '0)
    else $error("bad");
  chk_two_stage:
  assert property (cfg_ff == 8'h6a && ce_i && !aclr_i ##1 cfg_ff == 8'h6a &&
    ce_i && !aclr_i && !bus_i.wr |=> aclr_i || product_o == $past(e36, 2))
    else $error("bad");
  chk_cfg_read:
  assert property (bus_i.rd && bus_i.addr == 8'h00 |=>
    rd_data_o == {24'h0, $past(cfg_ff)}) else $error("bad");
  chk_stat_read:
  assert property (bus_i.rd && bus_i.addr == 8'h04 |=> rd_data_o ==
    {30'h0, $past(cfg_ff[0]), $past(product_signed_o)}) else $error("bad");
  cover property (cfg_ff == 8'h01);
  cover property (!ce_i && cfg_ff[6]);
  cover property (aclr_i && cfg_ff[6]);
endmodule : emb_multiplier_chk
bind emb_multiplier emb_multiplier_chk u_chk (.mclk_i, .rst_i, .aclr_i,
  .ce_i, .bus_i, .rd_data_o, .opnd_i, .product_o, .product_signed_o);

// ===== verif/emb_fabric_model.sv
`timescale 1ns/1ps
module emb_fabric_model
  import emb_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Operands out
  output emb_pkg::emb_opnd_t opnd_o
);
  initial opnd_o = '0;
  // Selects move only with a new operation
  task automatic send(input logic [17:0] a, b, input logic sa, sb);
    @(posedge mclk_i);
    opnd_o <= '{a: a, b: b, sign_a: sa, sign_b: sb};
  endtask : send
endmodule : emb_fabric_model

// ===== verif/emb_multiplier_bench.sv
`timescale 1ns/1ps
module emb_multiplier_bench;
  import emb_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic aclr_i = 1'b1;
  logic ce_i = 1'b1;
  emb_bus_t bus_i = '0;
  logic [EMB_DATAW-1:0] rd_data_o;
  emb_opnd_t opnd_i;
  logic [EMB_PRODW-1:0] product_o;
  logic product_signed_o;
  int n_fail = 0;
  int tests_run = 0;
  always #10 mclk_i = ~mclk_i;
  emb_multiplier dut (.mclk_i, .rst_i, .aclr_i, .ce_i, .bus_i, .rd_data_o,
    .opnd_i, .product_o, .product_signed_o);
  emb_fabric_model fab (.mclk_i, .opnd_o(opnd_i));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [35:0] mul(input logic [17:0] a, b,
    input logic sa, sb);
    logic [35:0] r;
    r = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
    return r;
  endfunction : mul
  task automatic bus_wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: ad, wdata: {24'hfffff0, d}, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i.wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge mclk_i);
    bus_i <= '{addr: ad, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i.rd <= 1'b0;
    #1 chk(36'(rd_data_o), 36'(e));
  endtask : bus_rd
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_sign();
    bus_wr(8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      fab.send(18'h3fffe, 18'h20003, i[1], i[0]);
      #1 chk(product_o, mul(18'h3fffe, 18'h20003, i[1], i[0]));
      chk(36'(product_signed_o), 36'(i[1] | i[0]));
    end
  endtask : t_sign
  task automatic t_pipe(input logic [7:0] cfg, input int lat);
    bus_wr(8'h00, cfg);
    fab.send(18'h2abcd ^ cfg, 18'h1fff3, 1'b1, 1'b0);
    repeat (lat) @(posedge mclk_i);
    #1 chk(product_o, mul(18'h2abcd ^ cfg, 18'h1fff3, 1, 0));
    chk(36'(product_signed_o), 36'h1);
    bus_rd(8'h00, {24'h0, cfg});
  endtask : t_pipe
  task automatic t_dual();
    bus_wr(8'h00, 8'h01);
    fab.send({9'h1ff, 9'h003}, {9'h002, 9'h1fe}, 1'b1, 1'b0);
    #1 chk(product_o, 36'hffff805fa);
    bus_rd(8'h04, 32'h3);
    bus_rd(8'h08, 32'h0);
  endtask : t_dual
  // Dual mode: low A section registered, high output section registered
  task automatic t_sect();
    bus_wr(8'h00, 8'h83);
    fab.send({9'h010, 9'h011}, {9'h00f, 9'h003}, 1'b0, 1'b0);
    fab.send({9'h0ff, 9'h1ff}, {9'h005, 9'h002}, 1'b0, 1'b0);
    #1 chk(product_o, 36'h003c00022);
  endtask : t_sect
  task automatic t_hold();
    bus_wr(8'h00, 8'h40);
    fab.send(18'h12345, 18'h00777, 1'b0, 1'b0);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    fab.send(18'h00001, 18'h00001, 1'b0, 1'b0);
    repeat (2) @(posedge mclk_i);
    #1 chk(product_o, mul(18'h12345, 18'h00777, 0, 0));
    aclr_i <= 1'b1;
    #1 chk(product_o, 36'h0);
    @(posedge mclk_i);
    aclr_i <= 1'b0;
    ce_i <= 1'b1;
  endtask : t_hold
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    aclr_i <= 1'b0;
    t_sign();
    t_pipe(8'h40, 1);
    t_pipe(8'h02, 1);
    t_pipe(8'h6a, 2);
    t_pipe(8'h00, 0);
    t_dual();
    t_sect();
    t_hold();
    wrap_up();
  end
endmodule : emb_multiplier_bench
